// >>> rtl/valve_supervisor.sv
// Valve actuator motor supervisor: direction, protection, positioner, pulsing.
// Assumes same-clock valve_pos and command inputs; phase pins are asynchronous.
`timescale 1ns/1ps
module valve_supervisor
	import valve_pkg::*;
#(
	parameter int unsigned TICK_CYC = TICK_CYC_DEF, // Cycles per 0.5 s tick.
	parameter int unsigned LOSS_CYC = LOSS_CYC_DEF  // Cycles before a silent phase is lost.
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	input  wire logic [2:0]       phase_in,
	input  wire logic [POS_W-1:0] valve_pos,
	input  wire logic [POS_W-1:0] cmd_pos,
	input  wire logic             cmd_valid,
	input  wire logic             open_cmd,
	input  wire logic             close_cmd,
	input  wire logic             stop_cmd,
	input  wire logic             fault_clear,
	input  wire logic             cfg_wr,
	input  wire cfg_t             cfg_in,
	output logic                  mot_open_r,
	output logic                  mot_close_r,
	output logic [7:0]            speed_r,
	output logic [POS_W-1:0]      pos_out_r,
	output logic                  monitor_relay_r,
	output status_t               status_r
);
	typedef enum {ST_IDLE, ST_RUN, ST_DEAD, ST_HOLD, ST_JAM_DEAD, ST_JAM_REV, ST_JAM_DEAD2,
		ST_JAM_FWD, ST_FAULT} state_t;

	state_t           state_r;     // Motor sequencer state.
	logic             dir_r;       // Travel direction, high for opening.
	logic [TMR_W-1:0] tmr_r;       // Ticks spent in the current state.
	logic [2:0]       jam_cnt_r;   // Driven ticks with no movement seen.
	logic [POS_W-1:0] pos_smp_r;   // Position at the last tick.
	logic [1:0]       man_r;       // Manual request: bit1 run, bit0 open.
	logic [31:0]      div_r;       // Tick divider.
	logic             tick;        // One-cycle 0.5 s enable.
	cfg_t             cfg_r;       // Live configuration.
	cfg_t             cfg_nxt;     // Clamped configuration to load.
	logic             ph_rev;      // Supply rotation reversed.
	logic             ph_lost;     // Supply phase missing.
	logic             moved;       // Position changed since the last tick.
	logic [POS_W-1:0] target;      // Positioner target.
	logic             pos_req;     // Positioner wants movement.
	logic             pos_open;    // Positioner direction.
	logic             near_sp;     // Inside the band, pulsing wanted.
	logic [POS_W:0]   err_abs;     // Distance to target.
	logic             req_run;     // Any run request.
	logic             req_open;    // Requested direction.
	logic             in_zone;     // Inside an enabled pulsing region.
	logic             near_ok;     // Positioner pulse gate.
	logic             zone_ok;     // Two-speed pulse gate.
	logic             drive_on;    // Motor energised this cycle.
	logic             running;     // Sequencer in a normal run state.

	// One 0.5 s enable from a free-running divider paces the sequencer and pulse timers.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_r <= '0;
		end else if (tick) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + 32'h00000001;
		end
	end
	assign tick = (div_r >= TICK_CYC - 1);

	phase_monitor #(
		.LOSS_CYC (LOSS_CYC)
	) u_phase (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.phase_in (phase_in),
		.rev_r    (ph_rev),
		.lost_r   (ph_lost)
	);

	// Proportional band, pulsing region, on/off periods, stop delay and preset are clamped to legal ranges as written.
	always_comb begin
		cfg_nxt = cfg_in;
		if (cfg_in.prop_band < PB_MIN) begin
			cfg_nxt.prop_band = PB_MIN;
		end else if (cfg_in.prop_band > POS_FULL) begin
			cfg_nxt.prop_band = POS_FULL;
		end
		if (cfg_in.ts_zone < ZONE_MIN) begin
			cfg_nxt.ts_zone = ZONE_MIN;
		end else if (cfg_in.ts_zone > ZONE_MAX) begin
			cfg_nxt.ts_zone = ZONE_MAX;
		end
		if (cfg_in.ts_on == 6'h00) begin
			cfg_nxt.ts_on = 6'h01;
		end else if (cfg_in.ts_on > ON_MAX) begin
			cfg_nxt.ts_on = ON_MAX;
		end
		if (cfg_in.ts_off == 8'h00) begin
			cfg_nxt.ts_off = 8'h01;
		end else if (cfg_in.ts_off > OFF_MAX) begin
			cfg_nxt.ts_off = OFF_MAX;
		end
		if (cfg_in.stop_delay > DELAY_MAX) begin
			cfg_nxt.stop_delay = DELAY_MAX;
		end
		if (cfg_in.preset > POS_FULL) begin
			cfg_nxt.preset = POS_FULL;
		end
	end

	// Configuration returns to its defaults on reset.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_r <= CFG_DEF;
		end else if (cfg_wr) begin
			cfg_r <= cfg_nxt;
		end
	end

	// Positioner target: polarity, then lost-command action.
	always_comb begin
		target = cfg_r.pol_close ? POS_FULL - cmd_pos : cmd_pos;
		if (!cmd_valid) begin
			case (cfg_r.loss_act)
				LOSS_OPEN:   target = POS_FULL;
				LOSS_CLOSE:  target = '0;
				LOSS_PRESET: target = cfg_r.preset;
				default:     target = valve_pos;
			endcase
		end
		if (target > POS_FULL) begin
			target = POS_FULL;
		end
		pos_open = target > valve_pos;
		err_abs  = pos_open ? {1'b0, target} - {1'b0, valve_pos} : {1'b0, valve_pos} - {1'b0, target};
		pos_req  = err_abs > {1'b0, cfg_r.dead_band};
		// Extreme targets run straight through without positioner pulsing.
		near_sp  = err_abs < {1'b0, cfg_r.prop_band} && target > EXT_LOW && target < EXT_HIGH;
	end

	// Manual travel latches on open/close; stop or a limit drops it.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			man_r <= 2'h0;
		end else if (stop_cmd) begin
			man_r <= 2'h0;
		end else if (open_cmd) begin
			man_r <= 2'h3;
		end else if (close_cmd) begin
			man_r <= 2'h2;
		end else if (man_r[1] && (man_r[0] ? valve_pos >= POS_FULL : valve_pos == '0)) begin
			man_r <= 2'h0;
		end
	end

	assign req_run  = cfg_r.pos_en ? pos_req : man_r[1];
	assign req_open = cfg_r.pos_en ? pos_open : man_r[0];
	assign running  = (state_r == ST_RUN);

	// The pulsing region counts back from the destination end.
	assign in_zone = dir_r ? (cfg_r.ts_open_en && valve_pos >= POS_FULL - cfg_r.ts_zone)
	                       : (cfg_r.ts_close_en && valve_pos <= cfg_r.ts_zone);

	pulse_timer u_near (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.tick      (tick),
		.en        (running && cfg_r.pos_en && near_sp),
		.on_ticks  (NEAR_ON),
		.off_ticks (NEAR_OFF),
		.gate_ok   (near_ok)
	);

	pulse_timer u_zone (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.tick      (tick),
		.en        (running && in_zone),
		.on_ticks  ({3'h0, cfg_r.ts_on}),
		.off_ticks ({cfg_r.ts_off, 1'b0}),
		.gate_ok   (zone_ok)
	);

	// Energised in run states; pulse gates apply to normal running.
	assign drive_on = (running && near_ok && zone_ok) || state_r inside {ST_JAM_REV, ST_JAM_FWD};

	// Movement is judged per tick against the last sample.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pos_smp_r <= '0;
		end else if (tick) begin
			pos_smp_r <= valve_pos;
		end
	end
	assign moved = tick && (valve_pos != pos_smp_r);

	// Jam counter: energised ticks with no movement.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			jam_cnt_r <= '0;
		end else if (!drive_on || state_r == ST_JAM_REV || moved) begin
			jam_cnt_r <= '0;
		end else if (tick && jam_cnt_r != 3'h7) begin
			jam_cnt_r <= jam_cnt_r + 3'h1;
		end
	end

	// Motor sequencer: starts, reversals, stop delay and jam recovery.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			dir_r   <= 1'b0;
			tmr_r   <= DEAD_TICKS;
		end else begin
			if (tick && tmr_r != '1) begin
				tmr_r <= tmr_r + 9'h001;
			end
			case (state_r)
				ST_IDLE: begin
					// A start against the last direction still waits out the dead time.
					if (req_run && !ph_lost && (req_open == dir_r || tmr_r >= DEAD_TICKS)) begin
						state_r <= ST_RUN;
						dir_r   <= req_open;
						tmr_r   <= '0;
					end
				end
				ST_RUN: begin
					if (ph_lost || !req_run) begin
						state_r <= cfg_r.pos_en ? ST_HOLD : ST_IDLE;
						tmr_r   <= '0;
					end else if (req_open != dir_r) begin
						state_r <= ST_DEAD;
						tmr_r   <= '0;
					end else if ({6'h00, jam_cnt_r} >= JAM_TICKS) begin
						state_r <= ST_JAM_DEAD;
						tmr_r   <= '0;
					end
				end
				ST_DEAD: begin
					// Both outputs stay off; counting two ticks gives 0.5 to 1.0 s.
					if (ph_lost || !req_run) begin
						state_r <= ST_IDLE;
					end else if (tmr_r >= DEAD_TICKS) begin
						state_r <= ST_RUN;
						dir_r   <= req_open;
						tmr_r   <= '0;
					end
				end
				ST_HOLD: begin
					if (tmr_r >= {2'h0, cfg_r.stop_delay, 1'b0}) begin
						state_r <= ST_IDLE;
					end
				end
				ST_JAM_DEAD: begin
					if (tmr_r >= DEAD_TICKS) begin
						state_r <= ST_JAM_REV;
						dir_r   <= ~dir_r;
						tmr_r   <= '0;
					end
				end
				ST_JAM_REV: begin
					if (tmr_r >= RECOV_TICKS) begin
						state_r <= ST_JAM_DEAD2;
						tmr_r   <= '0;
					end
				end
				ST_JAM_DEAD2: begin
					if (tmr_r >= DEAD_TICKS) begin
						state_r <= ST_JAM_FWD;
						dir_r   <= ~dir_r;
						tmr_r   <= '0;
					end
				end
				ST_JAM_FWD: begin
					// Freed if the valve moves; still stuck after the jam time means give up.
					if (moved) begin
						state_r <= ST_RUN;
						tmr_r   <= '0;
					end else if ({6'h00, jam_cnt_r} >= JAM_TICKS) begin
						state_r <= ST_FAULT;
					end
				end
				ST_FAULT: begin
					// Only an explicit clear after repair lets the motor run again.
					if (fault_clear) begin
						state_r <= ST_IDLE;
						tmr_r   <= '0;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
			// A lost phase abandons any recovery step at once.
			if (ph_lost && state_r inside {ST_JAM_DEAD, ST_JAM_REV, ST_JAM_DEAD2, ST_JAM_FWD}) begin
				state_r <= ST_IDLE;
			end
		end
	end

	// Direction outputs, swapped on reversed supply rotation.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mot_open_r  <= 1'b0;
			mot_close_r <= 1'b0;
		end else begin
			mot_open_r  <= drive_on && !ph_lost && (dir_r ^ ph_rev);
			mot_close_r <= drive_on && !ph_lost && !(dir_r ^ ph_rev);
		end
	end

	// Speed setting follows the travel direction.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			speed_r <= '0;
		end else begin
			speed_r <= dir_r ? cfg_r.spd_open : cfg_r.spd_close;
		end
	end

	// Position output may be flipped so its minimum means open.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pos_out_r <= '0;
		end else begin
			pos_out_r <= cfg_r.out_min_open ? POS_FULL - valve_pos : valve_pos;
		end
	end

	// Status and alarm relay; the relay is held energised only while healthy.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_r        <= '0;
			monitor_relay_r <= 1'b0;
		end else begin
			status_r.phase_rev  <= ph_rev;
			status_r.phase_lost <= ph_lost;
			status_r.jammed     <= state_r inside {ST_JAM_DEAD, ST_JAM_REV, ST_JAM_DEAD2, ST_JAM_FWD};
			status_r.jam_fault  <= state_r == ST_FAULT;
			status_r.cmd_lost   <= cfg_r.pos_en && !cmd_valid;
			status_r.moving     <= drive_on;
			monitor_relay_r     <= !(ph_lost || state_r == ST_FAULT);
		end
	end
endmodule : valve_supervisor

// >>> shared/valve_pkg.sv
// Constants and carrier types of the valve motor supervisor.
// Assumes one 200 MHz clock; positions in 0.1 % steps, 0 to 1000.
package valve_pkg;
	localparam int unsigned CLK_PERIOD_NS = 5;           // System clock period in ns.
	localparam int unsigned TICK_NS       = 500_000_000; // Base timer step, 0.5 s.
	localparam int unsigned TICK_CYC_DEF  = TICK_NS / CLK_PERIOD_NS;
	localparam int unsigned LOSS_MS       = 100;         // A phase silent this long is lost.
	localparam int unsigned LOSS_CYC_DEF  = LOSS_MS * 1_000_000 / CLK_PERIOD_NS;

	localparam int POS_W = 10; // Position and command width.
	localparam int TMR_W = 9;  // Tick counter width, up to 400 ticks (200 s).

	localparam logic [POS_W-1:0] POS_FULL    = 10'h3e8; // Fully open, 100 %.
	localparam logic [POS_W-1:0] EXT_LOW     = 10'h014; // 2 % extreme region edge.
	localparam logic [POS_W-1:0] EXT_HIGH    = 10'h3d4; // 98 % extreme region edge.
	localparam logic [POS_W-1:0] PB_MIN      = 10'h001; // Smallest band, 0.1 %.
	localparam logic [POS_W-1:0] ZONE_MIN    = 10'h005; // Smallest pulsing region, 0.5 %.
	localparam logic [POS_W-1:0] ZONE_MAX    = 10'h3de; // Largest pulsing region, 99 %.
	localparam logic [5:0]       ON_MAX      = 6'h28;   // Longest on-period, 40 half seconds.
	localparam logic [7:0]       OFF_MAX     = 8'hc8;   // Longest off-period, 200 s.
	localparam logic [5:0]       DELAY_MAX   = 6'h3c;   // Longest stop delay, 60 s.
	localparam logic [TMR_W-1:0] DEAD_TICKS  = 9'h002;  // Reversal dead time, 0.5 to 1.0 s.
	localparam logic [TMR_W-1:0] JAM_TICKS   = 9'h004;  // Driven ticks without movement.
	localparam logic [TMR_W-1:0] RECOV_TICKS = 9'h002;  // Length of the reverse recovery run.
	localparam logic [TMR_W-1:0] NEAR_ON     = 9'h001;  // Positioner pulse on near set point.
	localparam logic [TMR_W-1:0] NEAR_OFF    = 9'h001;  // Positioner pulse off near set point.

	typedef enum logic [1:0] {LOSS_OPEN, LOSS_CLOSE, LOSS_STOP, LOSS_PRESET} loss_act_t;

	typedef struct packed {
		logic             pos_en;       // Positioner mode.
		logic [POS_W-1:0] prop_band;    // Proportional band, 0.1 % units.
		logic [POS_W-1:0] dead_band;    // Dead band, 0.1 % units.
		logic             pol_close;    // Full scale command means closed.
		loss_act_t        loss_act;     // Action on lost command.
		logic [POS_W-1:0] preset;       // Preset position for lost command.
		logic [5:0]       stop_delay;   // Seconds after a positioning stop.
		logic             ts_open_en;   // Pulsing when opening.
		logic             ts_close_en;  // Pulsing when closing.
		logic [POS_W-1:0] ts_zone;      // Pulsing region size.
		logic [5:0]       ts_on;        // On-period, half seconds.
		logic [7:0]       ts_off;       // Off-period, seconds.
		logic [7:0]       spd_open;     // Opening speed setting.
		logic [7:0]       spd_close;    // Closing speed setting.
		logic             out_min_open; // Minimum position output means open.
	} cfg_t;

	localparam cfg_t CFG_DEF = '{pos_en: 1'b0, prop_band: 10'h032, dead_band: 10'h014,
		pol_close: 1'b0, loss_act: LOSS_CLOSE, preset: 10'h000, stop_delay: 6'h00,
		ts_open_en: 1'b0, ts_close_en: 1'b0, ts_zone: 10'h3de, ts_on: 6'h01, ts_off: 8'h01,
		spd_open: 8'hff, spd_close: 8'hff, out_min_open: 1'b0};

	typedef struct packed {
		logic phase_rev;  // Supply rotation found reversed.
		logic phase_lost; // A supply phase is missing.
		logic jammed;     // Jam recovery in progress.
		logic jam_fault;  // Recovery failed, motor inhibited.
		logic cmd_lost;   // Analog command lost.
		logic moving;     // Motor output energised.
	} status_t;
endpackage : valve_pkg

// >>> rtl/pulse_timer.sv
// On/off gate paced by the 0.5 s tick, opening with an on-period.
// Assumes tick is a one-cycle enable in the sys_clk domain.
`timescale 1ns/1ps
module pulse_timer
	import valve_pkg::*;
(
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	input  wire logic             tick,
	input  wire logic             en,
	input  wire logic [TMR_W-1:0] on_ticks,
	input  wire logic [TMR_W-1:0] off_ticks,
	output logic                  gate_ok
);
	logic             off_r; // High during the off-period.
	logic [TMR_W-1:0] cnt_r; // Ticks spent in the current period.

	// Restart with an on-period whenever pulsing is not wanted.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			off_r <= 1'b0;
			cnt_r <= '0;
		end else if (!en) begin
			off_r <= 1'b0;
			cnt_r <= '0;
		end else if (tick) begin
			if ((cnt_r + 9'h001) >= (off_r ? off_ticks : on_ticks)) begin
				off_r <= ~off_r;
				cnt_r <= '0;
			end else begin
				cnt_r <= cnt_r + 9'h001;
			end
		end
	end

	// A disabled timer never holds the motor back.
	assign gate_ok = !en || !off_r;
endmodule : pulse_timer

// >>> rtl/phase_monitor.sv
// Supply phase watcher: rotation order and missing-phase detection.
// Assumes three square-wave phase detector pins, asynchronous to sys_clk.
`timescale 1ns/1ps
module phase_monitor
	import valve_pkg::*;
#(
	parameter int unsigned LOSS_CYC = LOSS_CYC_DEF
) (
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic [2:0] phase_in,
	output logic            rev_r,
	output logic            lost_r
);
	logic [2:0]  s1_r;     // First synchroniser stage.
	logic [2:0]  s2_r;     // Second synchroniser stage.
	logic [2:0]  s3_r;     // Previous value for edge finding.
	logic [24:0] wd_r [3]; // Cycles since each phase last changed.

	// Two flops before any logic looks at the pins.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= phase_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// At a rising edge of the first phase the second is low in normal order.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rev_r <= 1'b0;
		end else if (s2_r[0] && !s3_r[0]) begin
			rev_r <= s2_r[1];
		end
	end

	// Each phase must keep toggling; a silent one counts as lost.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wd_r   <= '{default: '0};
			lost_r <= 1'b0;
		end else begin
			lost_r <= 1'b0;
			for (int i = 0; i < 3; i++) begin
				if (s2_r[i] != s3_r[i]) begin
					wd_r[i] <= '0;
				end else if (wd_r[i] >= 25'(LOSS_CYC)) begin
					lost_r <= 1'b1;
				end else begin
					wd_r[i] <= wd_r[i] + 25'h0000001;
				end
			end
		end
	end
endmodule : phase_monitor

// >>> tb/valve_supervisor_sva.sv
// Checker for the valve motor supervisor, bound to its top-level ports.
// Assumes one clock domain and the short tick chosen by the bench.
`timescale 1ns/1ps
module valve_supervisor_sva
	import valve_pkg::*;
#(
	parameter int unsigned TICK_CYC = TICK_CYC_DEF
) (
	input wire logic             sys_clk,
	input wire logic             rst_n,
	input wire logic [POS_W-1:0] valve_pos,
	input wire logic             cfg_wr,
	input wire cfg_t             cfg_in,
	input wire logic             mot_open_r,
	input wire logic             mot_close_r,
	input wire logic [7:0]       speed_r,
	input wire logic [POS_W-1:0] pos_out_r,
	input wire logic             monitor_relay_r,
	input wire status_t          status_r
);
	localparam int JAM_MAX  = 12 * TICK_CYC; // Whole recovery cycle with slack.
	localparam int DEAD_MIN = TICK_CYC - 1;  // Shortest legal both-off gap.
	logic [15:0] off_cnt_r;   // Cycles with both contactors off.
	logic        last_open_r; // Last energised output was the open one.
	logic [1:0]  age_r;       // Edges since reset or a config load.
	cfg_t        live_r;      // Shadow of the live configuration.

	// Gap counter saturates so a long idle spell cannot wrap into a short one.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) off_cnt_r <= 16'h0000;
		else if (mot_open_r || mot_close_r) off_cnt_r <= 16'h0000;
		else if (off_cnt_r != 16'hffff) off_cnt_r <= off_cnt_r + 16'h0001;
	end

	// Remembers the side that ran last, to spot a reversal.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) last_open_r <= 1'b0;
		else if (mot_open_r) last_open_r <= 1'b1;
		else if (mot_close_r) last_open_r <= 1'b0;
	end

	// Config-driven outputs are judged only once settled.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			age_r  <= 2'h0;
			live_r <= CFG_DEF;
		end else if (cfg_wr) begin
			age_r  <= 2'h0;
			live_r <= cfg_in;
		end else if (age_r != 2'h3) age_r <= age_r + 2'h1;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence both_off;
		!mot_open_r && !mot_close_r;
	endsequence
	sequence reversal;
		($rose(mot_close_r) && last_open_r) or ($rose(mot_open_r) && !last_open_r);
	endsequence

	one_side_a: assert property (!(mot_open_r && mot_close_r)) else $error("both outputs on");
	rev_dead_a: assert property (reversal |-> off_cnt_r >= DEAD_MIN) else $error("short gap");
	lost_relay_a: assert property (status_r.phase_lost |-> !monitor_relay_r) else $error("relay held");
	lost_block_a: assert property ($rose(mot_open_r) || $rose(mot_close_r) |->
		!$past(status_r.phase_lost)) else $error("start on lost phase");
	fault_stop_a: assert property (status_r.jam_fault && $past(status_r.jam_fault) |->
		!monitor_relay_r && !mot_open_r && !mot_close_r) else $error("fault not inhibiting");
	relay_ok_a: assert property (age_r == 2'h3 && !status_r.phase_lost && !status_r.jam_fault &&
		!$past(status_r.phase_lost) && !$past(status_r.jam_fault) |-> monitor_relay_r) else $error("relay off");
	speed_dir_a: assert property (age_r == 2'h3 && (mot_open_r || mot_close_r) &&
		$stable({mot_open_r, mot_close_r, status_r.phase_rev}) |-> speed_r ==
		((mot_open_r ^ status_r.phase_rev) ? live_r.spd_open : live_r.spd_close)) else $error("speed");
	pos_scale_a: assert property (age_r == 2'h3 |-> pos_out_r ==
		(live_r.out_min_open ? POS_FULL - $past(valve_pos) : $past(valve_pos))) else $error("pos out");
	jam_stop_a: assert property ($rose(status_r.jammed) |-> ##[0:2] both_off) else $error("jam run");
	jam_end_a: assert property ($rose(status_r.jammed) |-> ##[1:JAM_MAX] !status_r.jammed)
		else $error("recovery endless");
endmodule : valve_supervisor_sva

// >>> tb/valve_plant.sv
// Valve and supply model: one step a cycle when driven, three phase waves.
// Assumes reversed wiring swaps what the contactors do to the valve.
`timescale 1ns/1ps
module valve_plant
	import valve_pkg::*;
(
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	input  wire logic             mot_open_r,
	input  wire logic             mot_close_r,
	input  wire logic [1:0]       phase_mode,
	input  wire logic             stuck,
	output logic      [POS_W-1:0] valve_pos,
	output logic      [2:0]       phase_in
);
	logic [4:0] ph_cnt; // Step in a 24-cycle supply period.
	logic       up;     // Valve travels toward open.
	logic       down;   // Valve travels toward closed.
	logic       pa;     // Wave lagging a third of a period.
	logic       pb;     // Wave lagging two thirds.
	assign up   = phase_mode[0] ? mot_close_r : mot_open_r;
	assign down = phase_mode[0] ? mot_open_r : mot_close_r;
	assign pa   = ph_cnt >= 5'd8 && ph_cnt < 5'd20;
	assign pb   = ph_cnt >= 5'd16 || ph_cnt < 5'd4;
	// Mode 1 swaps two phases; mode 2 silences one, as a loss.
	assign phase_in = {phase_mode[0] ? pa : (pb & ~phase_mode[1]), phase_mode[0] ? pb : pa, ph_cnt < 5'd12};

	// Supply period counter.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) ph_cnt <= 5'd0;
		else ph_cnt <= (ph_cnt == 5'd23) ? 5'd0 : ph_cnt + 5'd1;
	end

	// A stuck valve ignores the motor.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) valve_pos <= 10'h1f4;
		else if (!stuck && up && valve_pos < POS_FULL) valve_pos <= valve_pos + 10'h001;
		else if (!stuck && down && valve_pos != 10'h000) valve_pos <= valve_pos - 10'h001;
	end
endmodule : valve_plant

// >>> tb/valve_supervisor_tb_top.sv
// Self-checking bench for the valve supervisor and valve model.
// Assumes a 10-cycle tick so every timed behaviour fits a short run.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
$display("wrong value at %0t: got %0h want %0h", $time, g, e); end end
`define WAITC(c, lim) for (n = 0; n < (lim) && !(c); n++) @(posedge sys_clk);
module valve_supervisor_tb_top;
	import valve_pkg::*;
	localparam int unsigned TCK = 10; // Cycles per tick, shortened.
	logic             sys_clk = 1'b0;
	logic             rst_n, cmd_valid, open_cmd, close_cmd, stop_cmd, fault_clear, cfg_wr, stuck, seen;
	logic             mot_open_r, mot_close_r, monitor_relay_r;
	logic [1:0]       phase_mode;
	logic [2:0]       phase_in;
	logic [POS_W-1:0] valve_pos, cmd_pos, pos_out_r, tgt;
	logic [7:0]       speed_r;
	cfg_t             cfg_in, cfg;
	status_t          status_r;
	int               n, i, checked = 0, err_total = 0;
	int               cycles = 0;

	valve_supervisor #(.TICK_CYC(TCK), .LOSS_CYC(50)) dut_u (.sys_clk, .rst_n, .phase_in, .valve_pos, .cmd_pos,
		.cmd_valid, .open_cmd, .close_cmd, .stop_cmd, .fault_clear, .cfg_wr, .cfg_in, .mot_open_r, .mot_close_r,
		.speed_r, .pos_out_r, .monitor_relay_r, .status_r);
	valve_plant plant_u (.sys_clk, .rst_n, .mot_open_r, .mot_close_r, .phase_mode, .stuck, .valve_pos, .phase_in);

	always #2.5 sys_clk = ~sys_clk;

	// Hang guard, far above the run's length.
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			err_total++;
			stop_test();
		end
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : stop_test

	// One-cycle manual command pulse: open, close, stop.
	task automatic cmd(input logic [2:0] v);
		{open_cmd, close_cmd, stop_cmd} <= v;
		@(posedge sys_clk);
		{open_cmd, close_cmd, stop_cmd} <= 3'h0;
		@(posedge sys_clk);
	endtask : cmd

	// Loads the bench copy of the configuration.
	task automatic set_cfg();
		cfg_in <= cfg;
		cfg_wr <= 1'b1;
		@(posedge sys_clk);
		cfg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask : set_cfg

	function automatic logic near(input logic [POS_W-1:0] a, input logic [POS_W-1:0] b);
		return ((a > b) ? a - b : b - a) <= 10'h016;
	endfunction : near

	// Waits for the positioner to rest, then checks it stays put.
	task automatic settle(input logic [POS_W-1:0] t);
		`WAITC(near(valve_pos, t) && !status_r.moving, 4000)
		repeat (4 * TCK) @(posedge sys_clk);
		`CHK(near(valve_pos, t), 1'b1)
		`CHK(status_r.moving, 1'b0)
	endtask : settle

	initial begin
		{rst_n, cmd_valid, open_cmd, close_cmd, stop_cmd, fault_clear, cfg_wr, stuck} = 8'h00;
		phase_mode = 2'h0;
		cmd_pos = 10'h000;
		cfg = CFG_DEF;
		cfg_in = CFG_DEF;
		void'($urandom(33));
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		`CHK(monitor_relay_r, 1'b1)
		cfg.spd_open = 8'($urandom_range(1, 254));
		cfg.spd_close = ~cfg.spd_open;
		set_cfg();
		cmd(3'h4);
		repeat (2) @(posedge sys_clk);
		`CHK({mot_open_r, mot_close_r}, 2'h2)
		`CHK(speed_r, cfg.spd_open)
		// Reversal straight from running, with no stop between.
		cmd(3'h2);
		`WAITC(!mot_open_r, 5)
		`WAITC(mot_close_r, 100)
		`CHK(n >= TCK - 1 && n <= 2 * TCK + 2, 1'b1)
		`CHK(mot_close_r, 1'b1)
		@(posedge sys_clk);
		`CHK(speed_r, cfg.spd_close)
		cmd(3'h1);
		phase_mode <= 2'h1;
		repeat (60) @(posedge sys_clk);
		`CHK(status_r.phase_rev, 1'b1)
		cmd(3'h4);
		`WAITC(mot_close_r, 3 * TCK + 5)
		`CHK({mot_open_r, mot_close_r}, 2'h1)
		cmd(3'h1);
		phase_mode <= 2'h2;
		`WAITC(status_r.phase_lost, 200)
		`CHK(monitor_relay_r, 1'b0)
		cmd(3'h2);
		repeat (3 * TCK) @(posedge sys_clk);
		`CHK({mot_open_r, mot_close_r}, 2'h0)
		phase_mode <= 2'h0;
		repeat (100) @(posedge sys_clk);
		`CHK(monitor_relay_r, 1'b1)
		// Jammed valve: recovery must try the other way, then give up.
		stuck <= 1'b1;
		seen = 1'b0;
		cmd(3'h4);
		for (n = 0; n < 400 && !status_r.jam_fault; n++) begin
			@(posedge sys_clk);
			seen |= status_r.jammed & mot_close_r;
		end
		`CHK(seen, 1'b1)
		`CHK({status_r.jam_fault, monitor_relay_r}, 2'h2)
		cmd(3'h2);
		repeat (3 * TCK) @(posedge sys_clk);
		`CHK({mot_open_r, mot_close_r}, 2'h0)
		stuck <= 1'b0;
		fault_clear <= 1'b1;
		@(posedge sys_clk);
		fault_clear <= 1'b0;
		repeat (4) @(posedge sys_clk);
		`CHK(monitor_relay_r, 1'b1)
		// Pulsing on opening only: one tick on, four ticks off.
		cfg.ts_open_en = 1'b1;
		cfg.ts_off = 8'h02;
		set_cfg();
		cmd(3'h4);
		`WAITC(mot_open_r, 3 * TCK + 5)
		`CHK(mot_open_r, 1'b1)
		`WAITC(!mot_open_r, 100)
		`WAITC(mot_open_r, 200)
		`CHK(n >= 4 * TCK - 1 && n <= 4 * TCK + 1, 1'b1)
		`WAITC(!mot_open_r, 200)
		`CHK(n >= TCK - 1 && n <= TCK + 1, 1'b1)
		cmd(3'h2);
		`WAITC(mot_close_r, 4 * TCK)
		`WAITC(!mot_close_r, 60)
		`CHK(n, 60)
		cmd(3'h1);
		cfg.out_min_open = 1'b1;
		set_cfg();
		repeat (3) @(posedge sys_clk);
		`CHK(pos_out_r, POS_FULL - valve_pos)
		// Positioner with random targets and both polarities.
		cfg.pos_en = 1'b1;
		cmd_valid <= 1'b1;
		for (i = 0; i < 3; i++) begin
			cmd_pos <= 10'($urandom_range(100, 900));
			cfg.pol_close = i[0];
			set_cfg();
			settle(i[0] ? POS_FULL - cmd_pos : cmd_pos);
		end
		// Every action on a lost command.
		cfg.preset = 10'h12c;
		cmd_valid <= 1'b0;
		for (i = 0; i < 4; i++) begin
			cfg.loss_act = loss_act_t'(i);
			set_cfg();
			tgt = (i == 0) ? POS_FULL : (i == 1) ? 10'h000 : (i == 2) ? valve_pos : cfg.preset;
			settle(tgt);
			`CHK(status_r.cmd_lost, 1'b1)
		end
		stop_test();
	end
endmodule : valve_supervisor_tb_top

bind valve_supervisor valve_supervisor_sva #(.TICK_CYC(TICK_CYC)) sva_u (.sys_clk, .rst_n,
	.valve_pos, .cfg_wr, .cfg_in, .mot_open_r, .mot_close_r, .speed_r, .pos_out_r, .monitor_relay_r, .status_r);
